// ### fsk_ctrl.sv
// Auto-answer, loopback and line control around an FSK modem
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fsk_ctrl #(
    parameter int TICK_CYCLES = fsk_pkg::TICK_CYC,
    parameter int BILL_TICKS  = fsk_pkg::BILL_TK,
    parameter int NOCAR_TICKS = fsk_pkg::NOCAR_TK,
    parameter int HOLD_TICKS  = fsk_pkg::HOLD_TK,
    parameter int CDON_TICKS  = fsk_pkg::CDON_TK,
    parameter int RING_TICKS  = fsk_pkg::RING_TK
) (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Line and modem chip side
    input  wire logic        ring_detect_in,
    input  wire logic        carrier_present,
    input  wire logic        rx_demod_data,
    output logic             tx_mod_data,
    output logic             tx_squelch,
    output logic             answer_mode_out,
    output logic             off_hook,
    output logic             loop_current_on,
    output logic             line_to_modem,
    // Data terminal side
    input  wire logic        terminal_tx_serial,
    input  wire logic        request_to_send_in,
    output logic             rx_data_out,
    output logic             clear_to_send,
    output logic             data_set_ready,
    output logic             carrier_detect_out,
    output logic             connect_led
);
    // Synchronised pins
    logic [fsk_pkg::IN_N-1:0] in_s;
    wire  ring_s = in_s[fsk_pkg::IN_RING];
    wire  car_s  = in_s[fsk_pkg::IN_CAR];
    wire  rxd_s  = in_s[fsk_pkg::IN_RXD];
    wire  txd_s  = in_s[fsk_pkg::IN_TXD];
    wire  rts_s  = in_s[fsk_pkg::IN_RTS];

    // Every pin input crosses in through two flops
    fsk_sync2 #(.W(fsk_pkg::IN_N)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({request_to_send_in, terminal_tx_serial,
                   rx_demod_data, carrier_present, ring_detect_in}),
        .q       (in_s)
    );

    // Tick divider, one-cycle enable every millisecond
    logic [fsk_pkg::DIV_W-1:0] div_r;
    logic                      tick_r;
    wire  div_end = (div_r ==
                     fsk_pkg::DIV_W'(TICK_CYCLES - 1));

    // Divider counts on the single clock, no derived clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_end ? '0 : div_r + 1'b1;
            tick_r <= div_end;
        end
    end

    // Control register and derived selections
    logic [fsk_pkg::CTRL_W-1:0] ctrl_r;
    wire  ans_sel  = ctrl_r[fsk_pkg::CTRL_ANS];
    wire  loop_sel = ctrl_r[fsk_pkg::CTRL_LOOP];
    wire  auto_en  = ctrl_r[fsk_pkg::CTRL_AUTO];
    wire  data_sel = ctrl_r[fsk_pkg::CTRL_DATA];

    // Sequencer state
    fsk_pkg::fsk_state_t st_r;
    fsk_pkg::fsk_state_t st_nxt;

    // Timer bank, one instance per sequence delay
    fsk_tmr_if tif [fsk_pkg::TMR_N] ();

    genvar gi;
    generate
        for (gi = 0; gi < fsk_pkg::TMR_N; gi++) begin : g_tmr
            assign tif[gi].tick = tick_r;
            fsk_timer u_tmr (
                .pclk    (pclk),
                .presetn (presetn),
                .tb      (tif[gi])
            );
        end
    endgenerate

    // Off-hook states of the automatic call; S_MAN is off-hook too but not counted
    wire  in_call  = (st_r == fsk_pkg::S_BILL) ||
                     (st_r == fsk_pkg::S_WAIT) ||
                     (st_r == fsk_pkg::S_DATA);

    // Timer loads; each reloads while its condition is not met
    assign tif[fsk_pkg::T_BILL].limit  = fsk_pkg::TMR_W'(BILL_TICKS);
    assign tif[fsk_pkg::T_NOCAR].limit = fsk_pkg::TMR_W'(NOCAR_TICKS);
    assign tif[fsk_pkg::T_HOLD].limit  = fsk_pkg::TMR_W'(HOLD_TICKS);
    assign tif[fsk_pkg::T_CDON].limit  = fsk_pkg::TMR_W'(CDON_TICKS);
    assign tif[fsk_pkg::T_RING].limit  = fsk_pkg::TMR_W'(RING_TICKS);
    // Billing delay runs only inside its own state
    assign tif[fsk_pkg::T_BILL].start  = (st_r != fsk_pkg::S_BILL);
    // No-carrier window counts from going off-hook
    assign tif[fsk_pkg::T_NOCAR].start = !in_call;
    // Hold one-shot is retriggered by every cycle of carrier
    assign tif[fsk_pkg::T_HOLD].start  = car_s;
    // On-delay needs carrier present without a break
    assign tif[fsk_pkg::T_CDON].start  = !car_s;
    // Ring end is a quiet gap after the last ring burst
    assign tif[fsk_pkg::T_RING].start  = ring_s;

    wire  bill_done  = tif[fsk_pkg::T_BILL].done;
    wire  nocar_done = tif[fsk_pkg::T_NOCAR].done;
    wire  hold_done  = tif[fsk_pkg::T_HOLD].done;
    wire  cdon_done  = tif[fsk_pkg::T_CDON].done;
    wire  ring_done  = tif[fsk_pkg::T_RING].done;

    // Abort causes
    wire  no_resp  = (st_r == fsk_pkg::S_WAIT) && nocar_done;
    wire  car_lost = (st_r == fsk_pkg::S_DATA) && hold_done;

    // Sequencer next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            fsk_pkg::S_IDLE: begin
                // Ringing only matters when answering automatically
                if (auto_en && ans_sel && ring_s) begin
                    st_nxt = fsk_pkg::S_RING;
                end else if (!auto_en && data_sel) begin
                    st_nxt = fsk_pkg::S_MAN;
                end
            end
            fsk_pkg::S_RING: begin
                if (!auto_en) begin
                    st_nxt = fsk_pkg::S_IDLE;
                end else if (ring_done && !ring_s) begin
                    st_nxt = fsk_pkg::S_BILL;
                end
            end
            fsk_pkg::S_BILL: begin
                if (!auto_en) begin
                    st_nxt = fsk_pkg::S_IDLE;
                end else if (bill_done) begin
                    st_nxt = fsk_pkg::S_WAIT;
                end
            end
            fsk_pkg::S_WAIT: begin
                // Answer tone out, waiting for the originate carrier
                if (!auto_en || no_resp) begin
                    st_nxt = fsk_pkg::S_IDLE;
                end else if (cdon_done) begin
                    st_nxt = fsk_pkg::S_DATA;
                end
            end
            fsk_pkg::S_DATA: begin
                if (!auto_en || car_lost) begin
                    st_nxt = fsk_pkg::S_IDLE;
                end
            end
            fsk_pkg::S_MAN: begin
                // Back to handset when software leaves data mode
                if (auto_en || !data_sel) begin
                    st_nxt = fsk_pkg::S_IDLE;
                end
            end
            default: begin
                st_nxt = fsk_pkg::S_IDLE;
            end
        endcase
    end

    // Next values of the handshake and line outputs
    wire  hook_nxt = (st_nxt == fsk_pkg::S_BILL) ||
                     (st_nxt == fsk_pkg::S_WAIT) ||
                     (st_nxt == fsk_pkg::S_DATA) ||
                     (st_nxt == fsk_pkg::S_MAN);
    // Transmitter stays quiet until the billing delay is over
    wire  talk_nxt = (st_nxt == fsk_pkg::S_WAIT) ||
                     (st_nxt == fsk_pkg::S_DATA) ||
                     (st_nxt == fsk_pkg::S_MAN);
    wire  cd_nxt   = (st_nxt == fsk_pkg::S_DATA) ||
                     ((st_nxt == fsk_pkg::S_MAN) && cdon_done);

    // Registered outputs
    logic cd_r;
    logic cts_r;
    logic dsr_r;
    logic hook_r;
    logic squelch_r;
    logic txd_r;
    logic rxd_r;
    logic led_r;
    logic line_r;
    logic ans_r;
    logic hold_r;    // Loop-current latch
    logic coff_r;    // Carrier-off latch

    // Clear to send needs carrier detect already up a cycle
    wire  cts_seq  = cd_r && cd_nxt;
    wire  cts_nxt  = loop_sel ? rts_s : cts_seq;
    // Mark tone is held until data may flow
    wire  txd_seq  = cts_seq ? txd_s : fsk_pkg::MARK;
    wire  txd_nxt  = loop_sel ? rxd_s : txd_seq;
    wire  rxd_nxt  = loop_sel ? txd_s : rxd_s;

    // Latch events
    wire  hold_set = hook_nxt && !hook_r;
    wire  hold_clr = car_lost || no_resp || !hook_nxt;
    wire  coff_set = car_lost || no_resp;

    // APB decode
    wire  sel_ctrl = (paddr == fsk_pkg::REG_CTRL);
    wire  sel_stat = (paddr == fsk_pkg::REG_STATUS);
    wire  mapped   = sel_ctrl || sel_stat;
    wire  setup    = psel && !penable;
    wire  access   = psel && penable && pready;
    wire  wr_ctrl  = access && pwrite && sel_ctrl;
    wire  wr_stat  = access && pwrite && sel_stat;
    wire  coff_clr = wr_stat && pwdata[fsk_pkg::ST_COFF];

    // Status word showing the block's own state
    wire [31:0] stat_w = {20'h0_0000, 1'b0, st_r,
                          2'b00, ring_s, coff_r, hold_r,
                          cts_r, cd_r, dsr_r};
    wire [31:0] ctrl_w = {28'h000_0000, ctrl_r};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_w :
                         sel_stat ? stat_w : 32'h0000_0000;

    // Sequencer and call outputs; abort returns them all to idle together, except clear to send in loopback
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= fsk_pkg::S_IDLE;
            cd_r      <= 1'b0;
            cts_r     <= 1'b0;
            dsr_r     <= 1'b0;
            hook_r    <= 1'b0;
            squelch_r <= 1'b1;
            led_r     <= 1'b0;
            line_r    <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            cd_r      <= cd_nxt;
            cts_r     <= cts_nxt;
            dsr_r     <= hook_nxt;
            hook_r    <= hook_nxt;
            squelch_r <= !talk_nxt;
            led_r     <= cd_nxt && hook_nxt;
            line_r    <= hook_nxt;
        end
    end

    // Data path flops, loopback switched on the fly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_r <= fsk_pkg::MARK;
            rxd_r <= fsk_pkg::MARK;
            ans_r <= 1'b0;
        end else begin
            txd_r <= txd_nxt;
            rxd_r <= rxd_nxt;
            ans_r <= ans_sel;
        end
    end

    // Loop-current latch: set on going off-hook, cleared on drop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 1'b0;
        end else if (hold_clr) begin
            hold_r <= 1'b0;
        end else if (hold_set) begin
            hold_r <= 1'b1;
        end
    end

    // Carrier-off latch; a new loss wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coff_r <= 1'b0;
        end else if (coff_set) begin
            coff_r <= 1'b1;
        end else if (coff_clr) begin
            coff_r <= 1'b0;
        end
    end

    // Control register, written at the APB access edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= fsk_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= pwdata[fsk_pkg::CTRL_W-1:0];
        end
    end

    // APB answer: one wait-free access phase, error when unmapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Output ports, each straight from a flop
    assign tx_mod_data        = txd_r;
    assign tx_squelch         = squelch_r;
    assign answer_mode_out    = ans_r;
    assign off_hook           = hook_r;
    assign loop_current_on    = hold_r;
    assign line_to_modem      = line_r;
    assign rx_data_out        = rxd_r;
    assign clear_to_send      = cts_r;
    assign data_set_ready     = dsr_r;
    assign carrier_detect_out = cd_r;
    assign connect_led        = led_r;
endmodule
`default_nettype wire

// ### fsk_pkg.sv
// Shared constants and types for the modem answer control block
package fsk_pkg;
    // Clock rate and the timer tick that all sequence delays count
    localparam int CLK_HZ   = 40_000_000;
    localparam int TICK_US  = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int DIV_W    = 16;

    // Sequence times in milliseconds, as figures of the call sequence
    localparam int BILL_MS  = 2000;   // Billing-delay squelch
    localparam int NOCAR_MS = 10000;  // No-carrier abort after off-hook
    localparam int HOLD_MS  = 100;    // Line-hold retriggerable one-shot
    localparam int CDON_MS  = 150;    // Carrier-detect on-delay
    localparam int RING_MS  = 500;    // Ring silence meaning ring ended

    // Same times as tick counts
    localparam int BILL_TK  = BILL_MS * 1000 / TICK_US;
    localparam int NOCAR_TK = NOCAR_MS * 1000 / TICK_US;
    localparam int HOLD_TK  = HOLD_MS * 1000 / TICK_US;
    localparam int CDON_TK  = CDON_MS * 1000 / TICK_US;
    localparam int RING_TK  = RING_MS * 1000 / TICK_US;

    // Timer bank layout
    localparam int TMR_W    = 14;
    localparam int TMR_N    = 5;
    localparam int T_BILL   = 0;
    localparam int T_NOCAR  = 1;
    localparam int T_HOLD   = 2;
    localparam int T_CDON   = 3;
    localparam int T_RING   = 4;

    // Synchronised pin positions
    localparam int IN_N     = 5;
    localparam int IN_RING  = 0;
    localparam int IN_CAR   = 1;
    localparam int IN_RXD   = 2;
    localparam int IN_TXD   = 3;
    localparam int IN_RTS   = 4;

    // APB register map
    localparam int          ADDR_W     = 12;
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;

    // Control register fields
    localparam int         CTRL_W    = 4;
    localparam int         CTRL_ANS  = 0;  // 1 answer, 0 originate
    localparam int         CTRL_LOOP = 1;  // Digital loopback
    localparam int         CTRL_AUTO = 2;  // Automatic answering
    localparam int         CTRL_DATA = 3;  // 1 modem on line, 0 handset
    localparam logic [3:0] CTRL_RST  = 4'h0;

    // Status register fields
    localparam int ST_DSR   = 0;
    localparam int ST_CD    = 1;
    localparam int ST_CTS   = 2;
    localparam int ST_HOLD  = 3;
    localparam int ST_COFF  = 4;  // Carrier-off latch, write 1 clears
    localparam int ST_RING  = 5;
    localparam int ST_STATE = 8;

    localparam logic MARK = 1'b1;

    // Call sequence states
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RING = 3'b001,
        S_BILL = 3'b010,
        S_WAIT = 3'b011,
        S_DATA = 3'b100,
        S_MAN  = 3'b101
    } fsk_state_t;
endpackage

// ### fsk_tmr_if.sv
// Carrier between the controller and one sequence timer
`timescale 1ns/100ps
`default_nettype none
interface fsk_tmr_if;
    logic                     start;  // Reload, held high to retrigger
    logic                     tick;   // Timer tick enable
    logic [fsk_pkg::TMR_W-1:0] limit; // Ticks to count
    logic                     done;   // Expired, stays until reload
    modport ctl (output start, output tick, output limit, input done);
    modport tmr (input start, input tick, input limit, output done);
endinterface
`default_nettype wire

// ### fsk_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module fsk_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Async in, synchronised out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;  // First stage, read only by second stage
    logic [W-1:0] q_r;     // Second stage

    // Two stages so metastability settles before logic looks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= d;
            q_r    <= meta_r;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// ### fsk_timer.sv
// Retriggerable down-counting timer for the call sequence
`timescale 1ns/100ps
`default_nettype none
module fsk_timer (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control from the sequencer
    fsk_tmr_if.tmr    tb
);
    logic [fsk_pkg::TMR_W-1:0] cnt_r;   // Remaining ticks
    logic                      run_r;   // Counting
    logic                      done_r;  // Expired flag

    // Reload wins over counting, so a held start retriggers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= '0;
            run_r  <= 1'b0;
            done_r <= 1'b0;
        end else if (tb.start) begin
            cnt_r  <= tb.limit;
            run_r  <= 1'b1;
            done_r <= 1'b0;
        end else if (run_r && tb.tick) begin
            if (cnt_r <= 1) begin
                // Last tick ends the interval
                cnt_r  <= '0;
                run_r  <= 1'b0;
                done_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    assign tb.done = done_r;
endmodule
`default_nettype wire

// ### fsk_ctrl_asserts.sv
// Port checker for the modem answer control block
`timescale 1ns/100ps
`default_nettype none
module fsk_ctrl_asserts #(
    parameter int TICK_CYCLES = 4,
    parameter int CDON_TICKS  = 3,
    parameter int NOCAR_TICKS = 100
) (
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // Line and terminal
    input wire logic        carrier_present,
    input wire logic        tx_squelch,
    input wire logic        off_hook,
    input wire logic        carrier_detect_out,
    input wire logic        clear_to_send,
    input wire logic        data_set_ready,
    input wire logic        connect_led
);
    // Timers may run one tick short or one tick long, never more
    localparam int CD_MIN = (CDON_TICKS - 1) * TICK_CYCLES;
    localparam int NC_MAX = (NOCAR_TICKS + 1) * TICK_CYCLES + 8;
    int wait_r;  // Cycles off-hook with no detect
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Restarts on detect or hang-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wait_r <= 0;
        else if (!off_hook || carrier_detect_out)
            wait_r <= 0;
        else
            wait_r <= wait_r + 1;
    end
    chk_ready_after_setup:
        assert property (psel && !penable |=> pready) else $error("late");
    chk_unmapped_err:
        assert property (pready && paddr > 12'h004 |-> pslverr)
            else $error("no slave error");
    chk_cd_on_delay:
        assert property ($rose(carrier_detect_out) |->
            $past(carrier_present, CD_MIN)) else $error("detect early");
    chk_cts_after_cd:
        assert property ($rose(carrier_detect_out) |=> clear_to_send)
            else $error("no clear to send");
    chk_led_hook:
        assert property (connect_led |-> off_hook) else $error("lamp");
    chk_bill_squelch:
        assert property ($rose(off_hook) && tx_squelch |=> tx_squelch [*8])
            else $error("tone in billing delay");
    chk_dsr_hook:
        assert property (off_hook |-> data_set_ready) else $error("dsr");
    chk_idle_outputs:
        assert property ($fell(off_hook) |-> tx_squelch && !data_set_ready
            && !carrier_detect_out && !clear_to_send) else $error("idle");
    chk_loss_drop:
        assert property (off_hook && carrier_detect_out && !carrier_present
            |-> ##[1:40] !off_hook) else $error("line held");
    chk_nocar_limit:
        assert property (wait_r <= NC_MAX) else $error("no timeout");
    cover property ($rose(clear_to_send));
    cover property ($fell(off_hook));
    cover property (pready && pslverr);
endmodule
bind fsk_ctrl fsk_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES),
    .CDON_TICKS(CDON_TICKS), .NOCAR_TICKS(NOCAR_TICKS)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .carrier_present(carrier_present), .tx_squelch(tx_squelch),
    .off_hook(off_hook), .carrier_detect_out(carrier_detect_out),
    .clear_to_send(clear_to_send), .data_set_ready(data_set_ready),
    .connect_led(connect_led));
`default_nettype wire

// ### fsk_line_model.sv
// Remote originating modem at the far end of the line
`timescale 1ns/100ps
`default_nettype none
module fsk_line_model (
    // Clock and bench controls
    input  wire logic       pclk,
    input  wire logic       answer_en,  // Remote is on the line
    input  wire logic [7:0] delay,      // Its own detect delay
    // Line as the block sees it
    input  wire logic       tx_squelch,
    output logic            carrier_present,
    output logic            rx_demod_data
);
    logic [7:0] heard = 8'h00;   // Cycles our tone was heard
    logic [8:0] prbs  = 9'h1ff;  // Test pattern register
    initial carrier_present = 1'h0;
    initial rx_demod_data = 1'h0;
    // Answer tone heard long enough: reply with own carrier
    always @(posedge pclk) begin
        if (!answer_en || tx_squelch)
            heard <= 8'h00;
        else if (heard != 8'hff)
            heard <= heard + 8'h01;
        carrier_present <= answer_en && heard >= delay;
        prbs <= {prbs[7:0], prbs[8] ^ prbs[4]};
        // No carrier: a bit that toggles every cycle, never the last held value
        rx_demod_data <= carrier_present ? prbs[8] : !rx_demod_data;
    end
endmodule
`default_nettype wire

// ### test_fsk_modem_auto_answer_control.sv
// Self-checking bench for the modem answer control block
`timescale 1ns/100ps
`default_nettype none
module test_fsk_modem_auto_answer_control;
    localparam int TK = 4, BILL = 20, NOCAR = 100, HOLD = 5;
    logic        pclk = '0, presetn = '0, psel = '0, penable = '0;
    logic        pwrite = '0, ring = '0, txs = '1, rts = '0, ans = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, wd, ctrl_m;
    logic        pready, pslverr, err, car, rxd, txo, sq, hook;
    logic        rxo, cts, dsr, cd, led, amo, lon, line;
    logic [7:0]  dly = 8'h04;
    logic [2:0]  lq[$], e;  // Expected serial bits still in flight
    int          fails = 0, comparisons = 0, cyc = 0, n;
    int          seed = 32'hf0862052;
    wire logic [2:0] watch = {cd, sq, hook};
    fsk_ctrl #(.TICK_CYCLES(TK), .BILL_TICKS(BILL), .NOCAR_TICKS(NOCAR),
        .HOLD_TICKS(HOLD), .CDON_TICKS(3), .RING_TICKS(4)) u_fsk_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ring_detect_in(ring),
        .carrier_present(car), .rx_demod_data(rxd), .tx_mod_data(txo),
        .tx_squelch(sq), .answer_mode_out(amo), .off_hook(hook),
        .loop_current_on(lon), .line_to_modem(line), .terminal_tx_serial(txs),
        .request_to_send_in(rts), .rx_data_out(rxo), .clear_to_send(cts),
        .data_set_ready(dsr), .carrier_detect_out(cd), .connect_led(led));
    fsk_line_model u_fsk_line_model (.pclk(pclk), .answer_en(ans),
        .delay(dly), .tx_squelch(sq), .carrier_present(car),
        .rx_demod_data(rxd));
    always #12.5 pclk = ~pclk;
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for ready however long it takes
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Counts falling edges until a watched output reaches v
    task automatic wait_for(input int w, input logic v);
        n = 0;
        while (watch[w] !== v && n < 1000) begin
            @(negedge pclk);
            n++;
        end
        check(32'(n < 1000), 32'h1);
    endtask
    task automatic ring_call;
        @(posedge pclk);
        ring <= 1'h1;
        repeat (10) @(posedge pclk);
        ring <= 1'h0;
    endtask
    // Random terminal data; lp=1 loopback, lp=0 data mode; 3-cycle lag
    task automatic stream(input logic lp);
        lq.delete();
        repeat (40) begin
            @(posedge pclk);
            {txs, rts} <= 2'($random(seed));
            @(negedge pclk);
            lq.push_back(lp ? {txs, rts, rxd} : {rxd, 1'h1, txs});
            if (lq.size() > 3) begin
                e = lq.pop_front();
                check(32'({rxo, cts, txo}), 32'(e));
            end
        end
    endtask
    task automatic stop_test;
        $display("Counts: %0d compared, %0d failed", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(negedge pclk);
        check({29'h0, sq, rxo, hook}, 32'h6);
        repeat (4) begin
            wd = $random(seed) & 32'hffff_fff3;
            apb(1'h1, 12'h000, wd);
            ctrl_m = wd & 32'h0000_000f;
            apb(1'h0, 12'h000, 32'h0);
            check(rd, ctrl_m);
        end
        apb(1'h0, 12'h008, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("Registers done");
        apb(1'h1, 12'h000, 32'h0000_0002);
        stream(1'h1);
        apb(1'h1, 12'h000, 32'h0000_0005);
        {ans, dly} <= {1'h1, 4'h0, 4'($random(seed))} + 9'h001;
        ring_call();
        wait_for(0, 1'h1);
        check({30'h0, dsr, sq}, 32'h3);
        wait_for(1, 1'h0);
        check(32'(n >= (BILL-1)*TK-2 && n <= (BILL+1)*TK+2), 32'h1);
        check({31'h0, txo}, 32'h1);
        wait_for(2, 1'h1);
        @(negedge pclk);
        check({27'h0, cts, led, amo, lon, line}, 32'h1f);
        apb(1'h0, 12'h004, 32'h0);
        check(rd & 32'h0000_073f, 32'h0000_040f);
        stream(1'h0);
        ans <= 1'h0;
        wait_for(0, 1'h0);
        check(32'(n >= (HOLD-1)*TK && n <= (HOLD+1)*TK+8), 32'h1);
        check({27'h0, sq, cd, cts, lon, line}, 32'h10);
        apb(1'h0, 12'h004, 32'h0);
        check(rd & 32'h0000_0018, 32'h0000_0010);
        apb(1'h1, 12'h004, 32'h0000_0010);
        apb(1'h0, 12'h004, 32'h0);
        check(rd & 32'h0000_0010, 32'h0);
        $display("Answered call done");
        ring_call();
        wait_for(0, 1'h1);
        wait_for(0, 1'h0);
        check(32'(n >= (NOCAR-1)*TK-2 && n <= (NOCAR+1)*TK+4), 32'h1);
        $display("No carrier done");
        apb(1'h1, 12'h000, 32'h0000_0008);
        ans <= 1'h1;
        wait_for(2, 1'h1);
        check({28'h0, hook, sq, line, amo}, 32'ha);
        apb(1'h1, 12'h000, 32'h0);
        wait_for(0, 1'h0);
        check({31'h0, dsr}, 32'h0);
        apb(1'h1, 12'h000, 32'h0000_0004);
        ring_call();
        repeat (40) @(negedge pclk);
        check({31'h0, hook}, 32'h0);
        $display("Manual call done");
        stop_test();
    end
endmodule
`default_nettype wire
